// *** core/sar_ctl.v ***
// Overview of operation
// - a low convert_start_n ends acquisition and starts a conversion.
// - at the end of approximation busy falls, then the code is pushed one clock later.
// - a running conversion is never restarted or aborted, even by power-down.
// - convert start works independently of chip select and read strobe.
// - start still low when busy falls: self-timed acquisition, then next conversion.
// - free running may exceed the nominal rate; output path tolerates it.
// - core drops into reduced power at the end of each conversion.
// - read interface stays active while the core is in reduced power.
// - serial output shares pins with the parallel bus.
// - coding select picks binary or two's complement except for the full-width parallel word.
// - outputs high impedance unless chip select and read are both low.
// - parallel port supports 18-bit, 16-bit and byte-wide transfers.
// - reads after conversion or during the next one show the previous result.
// - reference buffer on when refbuf_power_down low, off when high.
`timescale 1ns/1ps
`default_nettype none
`include "sar_ctl_defs.vh"

module sar_fifo #(
  parameter WIDTH = 18,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_wr;
  wire            do_rd;

  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem[rd_ptr_reg];
  assign do_wr     = in_valid & in_ready;
  assign do_rd     = out_valid & out_ready;

  always @(posedge clk)
  begin
    if (do_wr)
      mem[wr_ptr_reg] <= in_data;
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (do_wr)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (do_rd)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (do_wr && !do_rd)
        count_reg <= count_reg + 1'b1;
      else if (do_rd && !do_wr)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule

module sar_ctl #(
  parameter RES_W    = `SAR_RES_W,
  parameter CONV_CYC = `SAR_CONV_CYC,
  parameter ACQ_CYC  = `SAR_ACQ_CYC
) (
  input  wire             clk,
  input  wire             rst_b,
  input  wire             convert_start_n,
  input  wire             full_power_down,
  input  wire             refbuf_power_down,
  input  wire             output_coding_select,
  input  wire [1:0]       bus_width_sel,
  input  wire             serial_mode,
  input  wire             cs_n,
  input  wire             rd_n,
  input  wire [RES_W-1:0] sample_code,
  output reg              busy,
  output reg              core_low_power,
  output reg              refbuf_enable,
  output reg  [RES_W-1:0] data_out,
  output reg  [RES_W-1:0] data_oe,
  output reg              result_overflow
);
  localparam ST_IDLE = 3'h1;
  localparam ST_CONV = 3'h2;
  localparam ST_ACQ  = 3'h4;
  localparam CW      = 12;

  reg              rst_s1_reg;
  reg              rst_s2_reg;
  wire             rst_n;
  reg  [2:0]       cnv_sync_reg;
  reg  [2:0]       cs_sync_reg;
  reg  [2:0]       rd_sync_reg;
  reg              cnv_lvl_reg;
  reg              cnv_prev_reg;
  reg              cs_lvl_reg;
  reg              rd_lvl_reg;
  reg              rd_prev_reg;
  reg              byte_sel_reg;
  reg  [2:0]       state_reg;
  reg  [2:0]       state_next;
  reg  [CW-1:0]    cnt_reg;
  reg  [CW-1:0]    cnt_next;
  reg  [RES_W-1:0] held_code_reg;
  reg  [RES_W-1:0] result_reg;
  reg              push_reg;
  wire             cnv_fall;
  wire             fifo_in_ready;
  wire [RES_W-1:0] fifo_data;
  wire             fifo_valid;
  wire             pop;
  wire             drive;
  wire [RES_W-1:0] shown;

  function [RES_W-1:0] coded;
    input [RES_W-1:0] raw;
    input             binary;
    input             plain;
    begin
      coded = raw;
      if (!plain && !binary)
        coded[`SAR_MID_BIT] = ~raw[`SAR_MID_BIT];
    end
  endfunction

  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  // pins pass three flops; a level counts once stages two and three agree
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnv_sync_reg <= 3'h7;
      cs_sync_reg  <= 3'h7;
      rd_sync_reg  <= 3'h7;
      cnv_lvl_reg  <= 1'b1;
      cnv_prev_reg <= 1'b1;
      cs_lvl_reg   <= 1'b1;
      rd_lvl_reg   <= 1'b1;
      rd_prev_reg  <= 1'b1;
    end
    else
    begin
      cnv_sync_reg <= {cnv_sync_reg[1:0], convert_start_n};
      cs_sync_reg  <= {cs_sync_reg[1:0], cs_n};
      rd_sync_reg  <= {rd_sync_reg[1:0], rd_n};
      if (cnv_sync_reg[1] == cnv_sync_reg[2])
        cnv_lvl_reg <= cnv_sync_reg[2];
      if (cs_sync_reg[1] == cs_sync_reg[2])
        cs_lvl_reg <= cs_sync_reg[2];
      if (rd_sync_reg[1] == rd_sync_reg[2])
        rd_lvl_reg <= rd_sync_reg[2];
      cnv_prev_reg <= cnv_lvl_reg;
      rd_prev_reg  <= rd_lvl_reg;
    end
  end

  // start is decoded without reference to cs_n or rd_n
  assign cnv_fall = cnv_prev_reg & ~cnv_lvl_reg;

  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (cnv_fall)
        begin
          state_next = ST_CONV;
          cnt_next   = CONV_CYC[CW-1:0] - 1'b1;
        end
      end
      ST_CONV:
      begin
        // start edges and power-down are ignored until the count runs out
        if (cnt_reg == {CW{1'b0}})
        begin
          if (!cnv_lvl_reg)
          begin
            state_next = ST_ACQ;
            cnt_next   = ACQ_CYC[CW-1:0] - 1'b1;
          end
          else
            state_next = ST_IDLE;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      ST_ACQ:
      begin
        if (cnv_lvl_reg)
          state_next = ST_IDLE;
        else if (cnt_reg == {CW{1'b0}})
        begin
          state_next = ST_CONV;
          cnt_next   = CONV_CYC[CW-1:0] - 1'b1;
        end
        else
          cnt_next = cnt_reg - 1'b1;
      end
      default:
      begin
        state_next = ST_IDLE;
        cnt_next   = {CW{1'b0}};
      end
    endcase
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg      <= ST_IDLE;
      cnt_reg        <= {CW{1'b0}};
      busy           <= 1'b0;
      held_code_reg  <= {RES_W{1'b0}};
      push_reg       <= 1'b0;
      core_low_power <= 1'b1;
      refbuf_enable  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      if (state_reg != ST_CONV && state_next == ST_CONV)
        held_code_reg <= sample_code;
      // push_reg is set on the edge busy falls, so the code enters the fifo one clock after busy
      push_reg       <= (state_reg == ST_CONV) && (state_next != ST_CONV);
      busy           <= (state_next == ST_CONV);
      core_low_power <= (state_next != ST_CONV) | full_power_down & (state_next != ST_CONV);
      refbuf_enable  <= ~refbuf_power_down;
    end
  end

  // fifo absorbs free-running results faster than the host drains them
  sar_fifo #(
    .WIDTH (RES_W),
    .DEPTH (`SAR_FIFO_DEPTH),
    .AW    (4)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (held_code_reg),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (pop)
  );

  assign drive = ~cs_lvl_reg & ~rd_lvl_reg;
  // result advances only when no read is in progress
  assign pop   = fifo_valid & ~drive;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      result_reg      <= {RES_W{1'b0}};
      result_overflow <= 1'b0;
      byte_sel_reg    <= 1'b0;
    end
    else
    begin
      if (pop)
        result_reg <= fifo_data;
      if (push_reg && !fifo_in_ready)
        result_overflow <= 1'b1;
      // byte mode: each read strobe toggles between high and low byte
      if (cs_lvl_reg)
        byte_sel_reg <= 1'b0;
      else if (!rd_prev_reg && rd_lvl_reg && bus_width_sel == `SAR_WIDTH_8)
        byte_sel_reg <= ~byte_sel_reg;
    end
  end

  // only the full-width parallel word ignores the coding select; serial honours it
  assign shown = coded(result_reg, output_coding_select, !serial_mode && bus_width_sel != `SAR_WIDTH_16 &&
                       bus_width_sel != `SAR_WIDTH_8);

  // bus logic is clocked independently of the core power state
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_out <= {RES_W{1'b0}};
      data_oe  <= {RES_W{1'b0}};
    end
    else
    begin
      data_out <= {RES_W{1'b0}};
      data_oe  <= {RES_W{1'b0}};
      if (drive)
      begin
        if (serial_mode)
        begin
          data_out[0] <= shown[RES_W-1];
          data_oe[0]  <= 1'b1;
        end
        else
        begin
          case (bus_width_sel)
            `SAR_WIDTH_18:
            begin
              data_out <= shown;
              data_oe  <= {RES_W{1'b1}};
            end
            `SAR_WIDTH_16:
            begin
              data_out[15:0] <= shown[RES_W-1:2];
              data_oe[15:0]  <= 16'hFFFF;
            end
            `SAR_WIDTH_8:
            begin
              data_out[7:0] <= byte_sel_reg ? shown[9:2] : shown[RES_W-1:10];
              data_oe[7:0]  <= 8'hFF;
            end
            default:
            begin
              data_out <= shown;
              data_oe  <= {RES_W{1'b1}};
            end
          endcase
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** core/sar_ctl_defs.vh ***
`ifndef SAR_CTL_DEFS_VH
`define SAR_CTL_DEFS_VH
`define SAR_RES_W        18
`define SAR_CONV_NS      1400
`define SAR_ACQ_NS       350
`define SAR_CLK_MHZ      40
`define SAR_CONV_CYC     ((`SAR_CONV_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_ACQ_CYC      ((`SAR_ACQ_NS * `SAR_CLK_MHZ + 999) / 1000)
`define SAR_WIDTH_18     2'h0
`define SAR_WIDTH_16     2'h1
`define SAR_WIDTH_8      2'h2
`define SAR_MID_BIT      17
`define SAR_FIFO_DEPTH   16
`endif

// *** tb/sar_ctl_chk_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module sar_ctl_chk #(
  parameter CONV_CYC = 56,
  parameter ACQ_CYC  = 14
) (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        convert_start_n,
  input wire logic        refbuf_power_down,
  input wire logic [1:0]  bus_width_sel,
  input wire logic        serial_mode,
  input wire logic        cs_n,
  input wire logic        rd_n,
  input wire logic        busy,
  input wire logic        core_low_power,
  input wire logic        refbuf_enable,
  input wire logic [17:0] data_out,
  input wire logic [17:0] data_oe,
  input wire logic        result_overflow
);
  localparam int AMIN = ACQ_CYC;
  localparam int AMAX = ACQ_CYC + 6;
  int          cnt;
  logic [17:0] mask;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b) cnt <= 0;
    else cnt <= busy ? cnt + 1 : 0;
  // serial output shares bit 0 only, so its mask overrides the width
  always_comb mask = serial_mode ? 18'h00001 : bus_width_sel == 2'h1 ? 18'h0FFFF :
                     bus_width_sel == 2'h2 ? 18'h000FF : 18'h3FFFF;
  sequence s_read; (!cs_n && !rd_n) [*8]; endsequence
  sequence s_held; (!convert_start_n) [*6] ##0 $fell(busy); endsequence
  property p_start; !busy && $fell(convert_start_n) |-> ##[2:9] busy; endproperty
  property p_len; $fell(busy) |-> cnt == CONV_CYC; endproperty
  property p_free; s_held |-> ##[AMIN:AMAX] $rose(busy); endproperty
  property p_cpow; busy && $past(busy) |-> !core_low_power; endproperty
  property p_ipow; (!busy) [*3] |-> core_low_power; endproperty
  property p_rbuf; $stable(refbuf_power_down) [*5] |-> refbuf_enable == !refbuf_power_down; endproperty
  property p_hiz; (cs_n || rd_n) [*8] |-> data_oe == 18'h00000; endproperty
  property p_drive; s_read |-> data_oe == mask; endproperty
  property p_hold; s_read ##0 $past(data_oe) == mask |-> $stable(data_out); endproperty
  property p_ovf; result_overflow |=> result_overflow; endproperty
  a_start: assert property (p_start) else $error("start ignored");
  a_len: assert property (p_len) else $error("conversion length");
  a_free: assert property (p_free) else $error("no self start");
  a_cpow: assert property (p_cpow) else $error("low power in conversion");
  a_ipow: assert property (p_ipow) else $error("no low power");
  a_rbuf: assert property (p_rbuf) else $error("buffer enable");
  a_hiz: assert property (p_hiz) else $error("bus not floating");
  a_drive: assert property (p_drive) else $error("bus enable");
  a_hold: assert property (p_hold) else $error("data moved in read");
  a_ovf: assert property (p_ovf) else $error("overflow cleared");
endmodule
bind sar_ctl sar_ctl_chk #(.CONV_CYC(CONV_CYC), .ACQ_CYC(ACQ_CYC)) u_chk (
  .clk(clk), .rst_b(rst_b), .convert_start_n(convert_start_n), .refbuf_power_down(refbuf_power_down),
  .bus_width_sel(bus_width_sel), .serial_mode(serial_mode), .cs_n(cs_n), .rd_n(rd_n), .busy(busy),
  .core_low_power(core_low_power), .refbuf_enable(refbuf_enable), .data_out(data_out),
  .data_oe(data_oe), .result_overflow(result_overflow));
`default_nettype wire

// *** tb/sar_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sar_host (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic        keep,
  input  wire logic [17:0] dout,
  input  wire logic [17:0] doe,
  output var  logic        cs_n,
  output var  logic        rd_n,
  output var  logic        rv,
  output var  logic [17:0] rdat
);
  initial
  begin
    {cs_n, rd_n, rv} = 3'h6;
    rdat = 18'h00000;
  end
  // req is looked at on rising edges only; it changes on falling ones
  always
  begin
    @(posedge clk);
    if (req)
    begin
      @(negedge clk);
      cs_n = 1'b0;
      rd_n = 1'b0;
      @(posedge clk);
      while (doe === 18'h00000) @(posedge clk);
      repeat (2) @(posedge clk);
      @(negedge clk);
      rdat = dout & doe;
      rv = 1'b1;
      @(negedge clk);
      rv = 1'b0;
      @(posedge clk);
      while (req) @(posedge clk);
      @(negedge clk);
      rd_n = 1'b1;
      cs_n = ~keep;
      while (doe !== 18'h00000) @(posedge clk);
    end
  end
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk, rst_b, cnv_n, fpd, rpd, obs, ser, req, keep;
  logic        busy, lowp, rbe, ovf, cs_n, rd_n, rv;
  logic [1:0]  wsel;
  logic [17:0] code, prev, dout, doe, rdat;
  logic [17:0] q[$];
  int          failures = 0, num_checks = 0, cyc = 0, m;
  sar_ctl #(.CONV_CYC(48), .ACQ_CYC(3)) u_dut (
    .clk(clk), .rst_b(rst_b), .convert_start_n(cnv_n), .full_power_down(fpd), .refbuf_power_down(rpd),
    .output_coding_select(obs), .bus_width_sel(wsel), .serial_mode(ser), .cs_n(cs_n), .rd_n(rd_n),
    .sample_code(code), .busy(busy), .core_low_power(lowp), .refbuf_enable(rbe), .data_out(dout),
    .data_oe(doe), .result_overflow(ovf));
  sar_host u_host (.clk(clk), .req(req), .keep(keep), .dout(dout), .doe(doe), .cs_n(cs_n),
    .rd_n(rd_n), .rv(rv), .rdat(rdat));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict;
    if (failures == 0 && num_checks > 0 && q.size() == 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check_word(input logic [17:0] g, input logic [17:0] e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %0t: read %h expected %h", $time, g, e);
    end
  endtask
  task automatic check_flag(input logic g, input logic e);
    num_checks++;
    if (g !== e)
    begin
      failures++;
      $display("Error %0t: flag %b expected %b", $time, g, e);
    end
  endtask
  function automatic logic [17:0] expv(input logic [17:0] r, input logic [1:0] w, input logic ob,
                                       input logic lo);
    logic [17:0] c;
    c = (w == 2'h0 || w == 2'h3) ? r : {r[17] ^ ~ob, r[16:0]};
    if (w == 2'h1) expv = {2'h0, c[17:2]};
    else if (w == 2'h2) expv = lo ? {10'h000, c[9:2]} : {10'h000, c[17:10]};
    else expv = c;
  endfunction
  task automatic wait_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 100)
    begin
      @(negedge clk);
      n++;
    end
    check_flag(busy, v);
  endtask
  task automatic do_read(input logic k, input logic [17:0] e);
    int n;
    n = 0;
    q.push_back(e);
    keep = k;
    req = 1'b1;
    @(posedge clk);
    while (rv !== 1'b1 && n < 60)
    begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    req = 1'b0;
    while (doe !== 18'h00000 && n < 120)
    begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
  endtask
  task automatic conv(input logic during, input logic [17:0] e);
    cnv_n = 1'b0;
    wait_busy(1'b1);
    cnv_n = 1'b1;
    fpd = during;
    @(negedge clk);
    check_flag(lowp, 1'b0);
    if (during)
      do_read(1'b0, e);
    wait_busy(1'b0);
    check_flag(lowp, 1'b1);
    fpd = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  always @(posedge clk)
    if (rv === 1'b1)
      check_word(rdat, q.pop_front());
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      failures++;
      $display("Error %0t: run too long", $time);
      print_verdict;
    end
  end
  initial
  begin
    void'($urandom(32'h6AA342A9));
    {cnv_n, fpd, rpd, obs, ser, req, keep, rst_b} = 8'h80;
    wsel = 2'h0;
    code = 18'h00000;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    repeat (10) @(negedge clk);
    check_flag(rbe, 1'b1);
    rpd = 1'b1;
    repeat (4) @(negedge clk);
    check_flag(rbe, 1'b0);
    for (m = 0; m < 8; m++)
    begin
      wsel = (m == 6) ? 2'h0 : (m == 7) ? 2'h3 : m[2:1];
      obs = m[0];
      ser = (m == 6);
      code = 18'($urandom);
      conv(1'b0, 18'h00000);
      do_read(wsel == 2'h2, ser ? {17'h00000, code[17] ^ ~obs} : expv(code, wsel, obs, 1'b0));
      if (wsel == 2'h2)
        do_read(1'b0, expv(code, wsel, obs, 1'b1));
    end
    ser = 1'b0;
    prev = code;
    code = 18'($urandom);
    conv(1'b1, prev);
    do_read(1'b0, code);
    // a read held across many free-running conversions must overflow the result queue
    q.push_back(code);
    req = 1'b1;
    cnv_n = 1'b0;
    for (m = 0; m < 20; m++)
    begin
      wait_busy(1'b1);
      wait_busy(1'b0);
    end
    wait_busy(1'b1);
    cnv_n = 1'b1;
    req = 1'b0;
    wait_busy(1'b0);
    check_flag(ovf, 1'b1);
    repeat (30) @(negedge clk);
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    check_flag(ovf, 1'b0);
    check_flag(busy, 1'b0);
    rst_b = 1'b1;
    repeat (5) @(negedge clk);
    print_verdict;
  end
endmodule
`default_nettype wire
